// ==== src/extended_status_frame_builder.v ====
// Extended status frame builder for secure-session events.
// What this block does
// - Frames are emitted only while option bit 3 is set.
// - Each secure-session event produces one extended status frame.
// - Byte 0 is the start delimiter.
// - Bytes 1-2 hold the count between length and checksum.
// - Byte 3 is frame type 0x98.
// - Byte 4 is status code, then code-dependent data bytes.
// - Checksum is 0xFF minus low byte of sum from offset 3.
// - Established: code 0x3B, 64-bit address, options, 16-bit timeout.
// - Ended: code 0x3C, 64-bit address, reason byte.
// - Reason codes 0x00 to 0x04 as defined.
// - Auth failed: code 0x3D, 64-bit address, error byte.
`timescale 1ns/1ps
`include "ext_status_regs.vh"
module extended_status_frame_builder
(
  // Clock and reset.
  input  wire        clock,
  input  wire        rst_n,
  // Configuration.
  input  wire [7:0]  extended_api_options,
  // Event request.
  input  wire        evt_valid,
  input  wire [1:0]  evt_kind,
  input  wire [63:0] evt_addr,
  input  wire [7:0]  evt_detail,
  input  wire [15:0] evt_timeout,
  output wire        evt_ready,
  // Byte stream to the serial port.
  output reg         tx_valid_r,
  output reg  [7:0]  tx_data_r,
  output reg         tx_last_r,
  input  wire        tx_ready
);
  localparam KIND_ESTABLISHED = 2'd0;
  localparam KIND_ENDED       = 2'd1;
  localparam KIND_AUTH_FAIL   = 2'd2;

  localparam ST_IDLE  = 3'd0;
  localparam ST_LOAD  = 3'd1;
  localparam ST_HEAD  = 3'd2;
  localparam ST_BODY  = 3'd3;
  localparam ST_SUM   = 3'd4;

  reg  [2:0]  state_r;
  reg  [7:0]  code_r;
  reg  [63:0] addr_r;
  reg  [7:0]  detail_r;
  reg  [15:0] timeout_r;
  reg  [15:0] len_r;
  reg  [4:0]  pos_r;
  reg  [3:0]  idx_r;
  reg  [7:0]  sum_r;
  wire [7:0]  rom_data;

  function [7:0] kind_code;
    input [1:0] kind;
    begin
      case (kind)
        KIND_ESTABLISHED: kind_code = `CODE_ESTABLISHED;
        KIND_ENDED:       kind_code = `CODE_ENDED;
        default:          kind_code = `CODE_AUTH_FAIL;
      endcase
    end
  endfunction

  // Events are accepted only when idle; with the option clear they are dropped.
  assign evt_ready = (state_r == ST_IDLE);
  wire enabled = extended_api_options[`EXT_OPT_BIT];
  wire take    = evt_valid && evt_ready && enabled && (evt_kind != 2'd3);
  wire moved   = tx_valid_r && tx_ready;

  frame_byte_rom u_rom
  (
    .clock   (clock),
    .rst_n   (rst_n),
    .code    (code_r),
    .addr    (addr_r),
    .detail  (detail_r),
    .timeout (timeout_r),
    .index   (idx_r),
    .data_r  (rom_data)
  );

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= ST_IDLE;
      code_r     <= 8'h00;
      addr_r     <= 64'h0000000000000000;
      detail_r   <= 8'h00;
      timeout_r  <= 16'h0000;
      len_r      <= 16'h0000;
      pos_r      <= 5'd0;
      idx_r      <= 4'h0;
      sum_r      <= 8'h00;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_last_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            code_r    <= kind_code(evt_kind);
            addr_r    <= evt_addr;
            detail_r  <= evt_detail;
            timeout_r <= evt_timeout;
            len_r     <= (evt_kind == KIND_ESTABLISHED) ? `LEN_ESTABLISHED
                                                        : `LEN_TWO_FIELD;
            pos_r      <= 5'd0;
            sum_r      <= 8'h00;
            tx_valid_r <= 1'b1;
            tx_data_r  <= `START_BYTE;
            tx_last_r  <= 1'b0;
            state_r    <= ST_HEAD;
          end
        end
        ST_HEAD:
        begin
          if (moved)
          begin
            pos_r <= pos_r + 5'd1;
            case (pos_r)
              5'd0: tx_data_r <= len_r[15:8];
              5'd1: tx_data_r <= len_r[7:0];
              5'd2: tx_data_r <= `FRAME_TYPE_EXT;
              default: tx_data_r <= code_r;
            endcase
            // The checksum covers the frame type byte and everything after it.
            if (pos_r >= 5'd3)
              sum_r <= sum_r + tx_data_r;
            if (pos_r == 5'd4)
            begin
              idx_r      <= 4'h0;
              tx_valid_r <= 1'b0;
              state_r    <= ST_LOAD;
            end
          end
        end
        ST_LOAD:
        begin
          // The selected payload byte is valid one cycle after the index settles.
          state_r <= ST_BODY;
        end
        ST_BODY:
        begin
          if (!tx_valid_r)
          begin
            tx_valid_r <= 1'b1;
            tx_data_r  <= rom_data;
          end
          else if (moved)
          begin
            sum_r <= sum_r + tx_data_r;
            if ({12'h000, idx_r} + 16'd3 == len_r)
            begin
              tx_data_r <= `CHECKSUM_BASE - (sum_r + tx_data_r);
              tx_last_r <= 1'b1;
              state_r   <= ST_SUM;
            end
            else
            begin
              idx_r      <= idx_r + 4'h1;
              tx_valid_r <= 1'b0;
              state_r    <= ST_LOAD;
            end
          end
        end
        ST_SUM:
        begin
          if (moved)
          begin
            tx_valid_r <= 1'b0;
            tx_last_r  <= 1'b0;
            state_r    <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== src/ext_status_regs.vh ====
// Constants for the extended status frame builder.
`ifndef EXT_STATUS_REGS_VH
`define EXT_STATUS_REGS_VH
`define START_BYTE        8'h7E
`define FRAME_TYPE_EXT    8'h98
`define CODE_ESTABLISHED  8'h3B
`define CODE_ENDED        8'h3C
`define CODE_AUTH_FAIL    8'h3D
`define EXT_OPT_BIT       3
`define REASON_BY_PEER    8'h00
`define REASON_TIMEOUT    8'h01
`define REASON_BAD_CTR    8'h02
`define REASON_CTR_OVF    8'h03
`define REASON_NO_MEM     8'h04
`define LEN_ESTABLISHED   16'h000D
`define LEN_TWO_FIELD     16'h000B
`define CHECKSUM_BASE     8'hFF
`endif

// ==== src/frame_byte_rom.v ====
// Frame byte selector: returns the payload byte at a given index, registered.
`timescale 1ns/1ps
module frame_byte_rom
(
  // Clock and reset.
  input  wire        clock,
  input  wire        rst_n,
  // Latched event fields.
  input  wire [7:0]  code,
  input  wire [63:0] addr,
  input  wire [7:0]  detail,
  input  wire [15:0] timeout,
  // Lookup.
  input  wire [3:0]  index,
  output reg  [7:0]  data_r
);
  reg [7:0] data_nxt;

  // Payload bytes after the status code, most significant byte first.
  always @*
  begin
    case (index)
      4'h0: data_nxt = addr[63:56];
      4'h1: data_nxt = addr[55:48];
      4'h2: data_nxt = addr[47:40];
      4'h3: data_nxt = addr[39:32];
      4'h4: data_nxt = addr[31:24];
      4'h5: data_nxt = addr[23:16];
      4'h6: data_nxt = addr[15:8];
      4'h7: data_nxt = addr[7:0];
      4'h8: data_nxt = detail;
      4'h9: data_nxt = timeout[15:8];
      4'hA: data_nxt = timeout[7:0];
      default: data_nxt = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      data_r <= 8'h00;
    else
      data_r <= data_nxt;
  end
endmodule

// ==== dv/frame_sink.sv ====
// Serial port sink model that can stall the byte stream.
`timescale 1ns/1ps
module frame_sink
(
  // Clock and control.
  input  wire clock,
  input  wire stall,
  // Byte handshake.
  output reg  tx_ready
);
  initial tx_ready = 1'b1;
  // A stalling sink offers ready only every other cycle.
  always @(posedge clock)
    tx_ready <= #1 !stall || !tx_ready;
endmodule

// ==== dv/extended_status_frame_builder_props.sv ====
// Port assertions for the status frame builder.
`timescale 1ns/1ps
module esfb_props
(
  // Watched ports.
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] extended_api_options,
  input wire       evt_valid,
  input wire [1:0] evt_kind,
  input wire       evt_ready,
  input wire       tx_valid_r,
  input wire [7:0] tx_data_r,
  input wire       tx_last_r,
  input wire       tx_ready
);
  reg  [4:0] idx_r;
  reg  [7:0] sum_r;
  wire       take = evt_valid && evt_ready;
  wire       acc  = tx_valid_r && tx_ready;
  // Tracks the offset of the offered byte and the sum from offset 3.
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      {idx_r, sum_r} <= 13'h0000;
    else if (acc)
      {idx_r, sum_r} <= tx_last_r ? 13'h0000 :
        {idx_r + 5'h01, sum_r + (idx_r > 5'h02 ? tx_data_r : 8'h00)};
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_start; take && extended_api_options[3] && evt_kind != 2'h3 |=> tx_valid_r
    && tx_data_r == 8'h7E && idx_r == 5'h00; endproperty
  a_start: assert property (p_start) else $error("no start byte");
  property p_off; take && !extended_api_options[3] |=> !tx_valid_r [*8]; endproperty
  a_off: assert property (p_off) else $error("frame while disabled");
  property p_kind; take && evt_kind == 2'h3 |=> !tx_valid_r [*8]; endproperty
  a_kind: assert property (p_kind) else $error("frame for no event");
  property p_hold; tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_busy; tx_valid_r |-> !evt_ready; endproperty
  a_busy: assert property (p_busy) else $error("event taken mid frame");
  property p_len; acc && idx_r == 5'h01 |-> tx_data_r == 8'h00; endproperty
  a_len: assert property (p_len) else $error("length high byte");
  property p_type; acc && idx_r == 5'h03 |-> tx_data_r == 8'h98; endproperty
  a_type: assert property (p_type) else $error("frame type");
  property p_code; acc && idx_r == 5'h04 |-> tx_data_r inside {8'h3B, 8'h3C, 8'h3D};
  endproperty
  a_code: assert property (p_code) else $error("status code");
  property p_end; acc && tx_last_r |-> idx_r == 5'h0E || idx_r == 5'h10; endproperty
  a_end: assert property (p_end) else $error("frame size");
  property p_sum; acc && tx_last_r |-> tx_data_r == 8'hFF - sum_r; endproperty
  a_sum: assert property (p_sum) else $error("checksum");
endmodule
bind extended_status_frame_builder esfb_props chk_u (.clock, .rst_n, .extended_api_options,
  .evt_valid, .evt_kind, .evt_ready, .tx_valid_r, .tx_data_r, .tx_last_r, .tx_ready);

// ==== dv/tb_extended_status_frame_builder.sv ====
// Testbench for the extended status frame builder.
`timescale 1ns/1ps
module tb_extended_status_frame_builder;
  reg         clock, rst_n, evt_valid, stall;
  reg  [7:0]  extended_api_options, evt_detail, s;
  reg  [1:0]  evt_kind;
  reg  [63:0] evt_addr;
  reg  [15:0] evt_timeout;
  reg  [7:0]  e [0:16];
  wire        evt_ready, tx_valid_r, tx_last_r, tx_ready;
  wire [7:0]  tx_data_r;
  integer     miscompares = 0, checks_done = 0, i, n, w, r;
  extended_status_frame_builder dut_u (.clock, .rst_n, .extended_api_options, .evt_valid,
    .evt_kind, .evt_addr, .evt_detail, .evt_timeout, .evt_ready, .tx_valid_r, .tx_data_r,
    .tx_last_r, .tx_ready);
  frame_sink sink_u (.clock, .stall, .tx_ready);
  task check(input [63:0] seen, input [63:0] want);
    checks_done = checks_done + 1;
    if (seen !== want)
    begin
      miscompares = miscompares + 1;
      $display("unexpected tx byte %0d: expected %0h, seen %0h", i, want, seen);
    end
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Builds the expected frame, raises the event and checks every byte taken.
  task frame(input [1:0] k, input [63:0] a, input [7:0] d, input [15:0] t);
    n = (k == 2'h0) ? 17 : 15;
    {e[0], e[1], e[2], e[3], e[4]} = {16'h7E00, n[7:0] - 8'h04, 8'h98, 8'h3B + k};
    for (i = 0; i < 8; i = i + 1)
      e[5 + i] = a[63 - 8 * i -: 8];
    {e[13], e[14], e[15]} = {d, t};
    s = 8'h00;
    for (i = 3; i < n - 1; i = i + 1)
      s = s + e[i];
    e[n - 1] = 8'hFF - s;
    {evt_kind, evt_addr, evt_detail, evt_timeout, evt_valid} = {k, a, d, t, 1'b1};
    @(posedge clock);
    #1 evt_valid = 1'b0;
    for (i = 0; i < n; i = i + 1)
    begin
      w = 0;
      do @(negedge clock); while (!(tx_valid_r && tx_ready) && ++w < 40);
      check(tx_data_r, e[i]);
      check(tx_last_r, i == n - 1);
      @(posedge clock);
    end
    #1;
  endtask
  task no_frame(input [7:0] o, input [1:0] k);
    {extended_api_options, evt_kind, evt_valid} = {o, k, 1'b1};
    @(posedge clock);
    #1 evt_valid = 1'b0;
    w = 0;
    repeat (20) @(negedge clock) w = w + tx_valid_r;
    check(w, 0);
    #1 extended_api_options = 8'h08;
    $display("test no_frame done");
  endtask
  task t_established;
    stall = 1'b1;
    frame(2'h0, 64'h0013A20012345678, 8'h00, 16'h4650);
    stall = 1'b0;
    $display("test established done");
  endtask
  task t_ended;
    for (r = 0; r < 5; r = r + 1)
      frame(2'h1, 64'h8000000000000001, r[7:0], 16'hFFFF);
    $display("test ended done");
  endtask
  task t_auth;
    frame(2'h2, 64'hFFFFFFFFFFFFFFFF, 8'hFF, 16'h0000);
    $display("test auth done");
  endtask
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    test_done;
  end
  initial
  begin
    {rst_n, evt_valid, stall, evt_kind, evt_addr, evt_detail, evt_timeout} = 0;
    extended_api_options = 8'h08;
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    t_established;
    t_ended;
    t_auth;
    no_frame(8'hF7, 2'h0);
    no_frame(8'h08, 2'h3);
    test_done;
  end
endmodule
